/* dv/csmm_app_model.sv */
// application-side model: latches each mirrored group by its index
module csmm_app_model (
  input wire clock,
  input wire rst_n,
  input wire [31:0] config_mirror_bus_ff,
  input wire [3:0] config_mirror_index_ff,
  input wire [52:0] config_status_bus_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] grp [16]; // last value seen per group
  logic [15:0] link_sts; // link status taken while link control is shown
  // latch every cycle; the bus is steady for the whole period so any cycle will do
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      link_sts <= 16'h0000;
    end else begin
      grp[config_mirror_index_ff] <= config_mirror_bus_ff;
      if (config_mirror_index_ff == 4'h2) begin
        link_sts <= config_status_bus_ff[46:31];
      end
    end
  end
  // size code to bytes; codes above 5 are reserved and decode to 0
  function automatic int size_bytes(input logic [2:0] code);
    return (code <= 3'h5) ? (128 << code) : 0;
  endfunction
  // root-port-only groups are latched but an endpoint user must not rely on them
endmodule

/* dv/csmm_top_bench.sv */
// self-checking bench: register writes, readback, and mirrored group contents
`include "csmm_regs.vh"
module csmm_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  wire [31:0] rdata_ff;
  wire [31:0] config_mirror_bus_ff;
  wire [3:0] config_mirror_index_ff;
  wire [52:0] config_status_bus_ff;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [31:0] rv;
  csmm_top #(.HOLD_CYCLES(8)) i_csmm_top (.clock(clock), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata_ff(rdata_ff),
    .config_mirror_bus_ff(config_mirror_bus_ff),
    .config_mirror_index_ff(config_mirror_index_ff),
    .config_status_bus_ff(config_status_bus_ff));
  csmm_app_model i_csmm_app_model (.clock(clock), .rst_n(rst_n),
    .config_mirror_bus_ff(config_mirror_bus_ff),
    .config_mirror_index_ff(config_mirror_index_ff),
    .config_status_bus_ff(config_status_bus_ff));
  // free-running 100 MHz clock
  initial begin
    forever #5 clock = ~clock;
  end
  // hang guard: the sequence needs well under 1500 cycles
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      complete_run();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask
  // one-cycle read strobe; data stands only in the following cycle
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1 d = rdata_ff;
  endtask
  // wait two full rounds so every group is sampled after the last write
  task automatic two_rounds();
    repeat (2 * 16 * 8 + 4) @(posedge clock);
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    #1 chk("reset index", 32'hf, {28'h0, config_mirror_index_ff});
    wr(`CSMM_ADDR_DEV_CTRL, 32'h000050a0);
    wr(`CSMM_ADDR_DEV_CTRL2, 32'h00001234);
    wr(`CSMM_ADDR_SLOT_CTRL, 32'h0000abcd);
    wr(`CSMM_ADDR_LINK_CTRL, 32'h00000041);
    wr(`CSMM_ADDR_LINK_CTRL2, 32'h00000002);
    wr(`CSMM_ADDR_CMD_ROOT, 32'hffffffff);
    wr(`CSMM_ADDR_MSI_DATA_BUSDEV, 32'hffffffff);
    wr(`CSMM_ADDR_ECRC_TCVC, 32'hffffffff);
    wr(`CSMM_ADDR_LINK_STATUS, 32'h00008011);
    wr(`CSMM_ADDR_MODE, 32'h00000000);
    wr(8'h7c, 32'hdeadbeef);
    rd(`CSMM_ADDR_DEV_CTRL, rv);
    chk("devctl readback", 32'h000050a0, rv);
    rd(8'h7c, rv);
    chk("unmapped read", 32'h0, rv);
    rd(`CSMM_ADDR_INDEX, rv);
    // strobe sampled at edge 33; index reached 2 at edge 30 (first step at edge 14)
    chk("index read", 32'h00000002, rv);
    wr(`CSMM_ADDR_SEC_BUS, 32'h11223344);
    wr(`CSMM_ADDR_MSI_ADDR_LO, 32'h12345678);
    wr(`CSMM_ADDR_MSI_ADDR_HI, 32'h87654321);
    wr(`CSMM_ADDR_IO_BASE, 32'h0009abcd);
    wr(`CSMM_ADDR_IO_LIMIT, 32'h0000fedc);
    wr(`CSMM_ADDR_NP, 32'h00abc123);
    wr(`CSMM_ADDR_PF_BASE_LO, 32'h01010101);
    wr(`CSMM_ADDR_PF_BASE_HI, 32'hfedcba98);
    wr(`CSMM_ADDR_PF_LIM_LO, 32'h02020202);
    wr(`CSMM_ADDR_PF_LIM_HI, 32'h76543210);
    wr(`CSMM_ADDR_PMCSR, 32'h0badf00d);
    wr(`CSMM_ADDR_MSI_CTRL, 32'hc0de5eed);
    two_rounds();
    chk("group 0", 32'h50a01234, i_csmm_app_model.grp[0]);
    chk("mrrs bytes", 32'd4096, i_csmm_app_model.size_bytes(i_csmm_app_model.grp[0][30:28]));
    chk("mps bytes", 32'd4096, i_csmm_app_model.size_bytes(i_csmm_app_model.grp[0][23:21]));
    chk("group 1", 32'h0000abcd, i_csmm_app_model.grp[1]);
    chk("group 2", 32'h00410002, i_csmm_app_model.grp[2]);
    chk("group 3", 32'h00ffffff, i_csmm_app_model.grp[3]);
    chk("group 4", 32'h11223344, i_csmm_app_model.grp[4]);
    chk("group 5", 32'h6789abcd, i_csmm_app_model.grp[5]);
    chk("group 6", 32'h3210fedc, i_csmm_app_model.grp[6]);
    chk("group 7", 32'h00abc123, i_csmm_app_model.grp[7]);
    chk("group 8", 32'h01010101, i_csmm_app_model.grp[8]);
    chk("group 9", 32'h210cba98, i_csmm_app_model.grp[9]);
    chk("group a", 32'h02020202, i_csmm_app_model.grp[10]);
    chk("group b", 32'h76543fed, i_csmm_app_model.grp[11]);
    chk("group c", 32'h0badf00d, i_csmm_app_model.grp[12]);
    chk("group d", 32'hc0de5eed, i_csmm_app_model.grp[13]);
    chk("group e", 32'h03ffffff, i_csmm_app_model.grp[14]);
    chk("group f", 32'hffff1fff, i_csmm_app_model.grp[15]);
    chk("gen1 link status", 32'h00000011, {16'h0, i_csmm_app_model.link_sts});
    wr(`CSMM_ADDR_LINK_STATUS, 32'h00000011);
    wr(`CSMM_ADDR_MODE, 32'h00000003);
    two_rounds();
    chk("gen2 link status", 32'h00008011, {16'h0, i_csmm_app_model.link_sts});
    rd(`CSMM_ADDR_MODE, rv);
    chk("mode readback", 32'h00000003, rv);
    rd(`CSMM_ADDR_LINK_STATUS, rv);
    chk("link status readback", 32'h00008011, rv);
    complete_run();
  end
endmodule
bind csmm_top csmm_top_properties #(.HOLD_CYCLES(HOLD_CYCLES)) i_csmm_top_properties (
  .clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
  .rdata_ff(rdata_ff), .config_mirror_bus_ff(config_mirror_bus_ff),
  .config_mirror_index_ff(config_mirror_index_ff),
  .config_status_bus_ff(config_status_bus_ff));

/* dv/csmm_top_properties.sv */
// concurrent checks on the mirror bus, index, status bus and register read port
`include "csmm_regs.vh"
module csmm_top_properties #(
  parameter HOLD_CYCLES = 8
) (
  input wire clock,
  input wire rst_n,
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr_en,
  input wire rd_en,
  input wire [31:0] rdata_ff,
  input wire [31:0] config_mirror_bus_ff,
  input wire [3:0] config_mirror_index_ff,
  input wire [52:0] config_status_bus_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // one group period: index steady for the rest of the period, then it steps
  sequence group_hold_s;
    $stable(config_mirror_index_ff) [*7] ##1 $changed(config_mirror_index_ff);
  endsequence
  index_step_a: assert property ($changed(config_mirror_index_ff) |->
    config_mirror_index_ff == 4'($past(config_mirror_index_ff) + 4'h1))
    else $error("index did not step by one");
  index_period_a: assert property ($changed(config_mirror_index_ff) |=> group_hold_s)
    else $error("index period is not eight cycles");
  bus_steady_a: assert property (!$changed(config_mirror_index_ff) |->
    $stable(config_mirror_bus_ff)) else $error("bus moved without index change");
  slot_upper_a: assert property (config_mirror_index_ff == 4'h1 |->
    config_mirror_bus_ff[31:16] == 16'h0000) else $error("slot group upper half not zero");
  ecrc_upper_a: assert property (config_mirror_index_ff == 4'he |->
    config_mirror_bus_ff[31:26] == 6'h00) else $error("ecrc group top bits not zero");
  pad_fields_a: assert property ((config_mirror_index_ff == 4'h3 ||
    config_mirror_index_ff == 4'h7) |-> config_mirror_bus_ff[31:24] == 8'h00)
    else $error("pad byte not zero");
  msi_pad_a: assert property (config_mirror_index_ff == 4'hf |->
    config_mirror_bus_ff[15:13] == 3'h0) else $error("pad bits at group f not zero");
  status_spare_a: assert property (config_status_bus_ff[52:47] == 6'h00 &&
    config_status_bus_ff[30:0] == 31'h0) else $error("spare status bits not zero");
  read_idle_a: assert property (!$past(rd_en) |-> rdata_ff == 32'h0)
    else $error("read data outside read cycle");
  index_read_a: assert property (rd_en && addr == `CSMM_ADDR_INDEX |=>
    rdata_ff == {28'h0, $past(config_mirror_index_ff)}) else $error("index read wrong");
endmodule

/* hdl/csmm_hold_timer.v */
// divider that pulses once every hold period to advance the mirror index
module csmm_hold_timer #(
  parameter HOLD = 8,
  parameter CW = 3
) (
  input wire clock,
  input wire rst_n,
  output reg step_ff
);
  localparam integer LAST = HOLD - 1; // count of the final cycle, any hold length that fits
  reg [CW-1:0] cnt_ff; // cycles spent on the current group
  wire last_cycle = (cnt_ff == LAST[CW-1:0]);
  // free-running count; one pulse at the last cycle of each period
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= {CW{1'b0}};
      step_ff <= 1'b0;
    end else begin
      cnt_ff <= last_cycle ? {CW{1'b0}} : cnt_ff + {{(CW-1){1'b0}}, 1'b1};
      step_ff <= last_cycle;
    end
  end
endmodule

/* hdl/csmm_regs.vh */
// register offsets, field positions, reset values and timing for the config mirror block
`ifndef CSMM_REGS_VH
`define CSMM_REGS_VH
// software register indices (byte address on the plain port)
`define CSMM_ADDR_DEV_CTRL 8'h00
`define CSMM_ADDR_DEV_CTRL2 8'h04
`define CSMM_ADDR_SLOT_CTRL 8'h08
`define CSMM_ADDR_LINK_CTRL 8'h0c
`define CSMM_ADDR_LINK_CTRL2 8'h10
`define CSMM_ADDR_CMD_ROOT 8'h14
`define CSMM_ADDR_SEC_BUS 8'h18
`define CSMM_ADDR_MSI_ADDR_LO 8'h1c
`define CSMM_ADDR_MSI_ADDR_HI 8'h20
`define CSMM_ADDR_IO_BASE 8'h24
`define CSMM_ADDR_IO_LIMIT 8'h28
`define CSMM_ADDR_NP 8'h2c
`define CSMM_ADDR_PF_BASE_LO 8'h30
`define CSMM_ADDR_PF_BASE_HI 8'h34
`define CSMM_ADDR_PF_LIM_LO 8'h38
`define CSMM_ADDR_PF_LIM_HI 8'h3c
`define CSMM_ADDR_PMCSR 8'h40
`define CSMM_ADDR_MSI_CTRL 8'h44
`define CSMM_ADDR_ECRC_TCVC 8'h48
`define CSMM_ADDR_MSI_DATA_BUSDEV 8'h4c
`define CSMM_ADDR_LINK_STATUS 8'h50
`define CSMM_ADDR_MODE 8'h54
`define CSMM_ADDR_INDEX 8'h58
// device control fields
`define CSMM_MRRS_MSB 14
`define CSMM_MRRS_LSB 12
`define CSMM_MPS_MSB 7
`define CSMM_MPS_LSB 5
`define CSMM_SIZE_CODE_MAX 3'h5
// ecrc positions on the mirror bus at index e
`define CSMM_TX_ECRC_BIT 25
`define CSMM_RX_ECRC_BIT 24
// link status position on the status bus and bandwidth notification bit
`define CSMM_STS_LINK_MSB 46
`define CSMM_STS_LINK_LSB 31
`define CSMM_LINK_BW_BIT 15
// mode register bits
`define CSMM_MODE_GEN2_BIT 0
`define CSMM_MODE_ROOT_BIT 1
// reset values
`define CSMM_RST_16 16'h0000
`define CSMM_RST_32 32'h00000000
// cycles each group is held on the bus
`define CSMM_HOLD_CYCLES 8
`endif

/* hdl/csmm_top.v */
// configuration-space mirror: register file and time-multiplexed broadcast bus
`include "csmm_regs.vh"
module csmm_top #(
  parameter HOLD_CYCLES = `CSMM_HOLD_CYCLES
) (
  input wire clock,
  input wire rst_n,
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr_en,
  input wire rd_en,
  output reg [31:0] rdata_ff,
  output reg [31:0] config_mirror_bus_ff,
  output reg [3:0] config_mirror_index_ff,
  output reg [52:0] config_status_bus_ff
);
  // configuration-space shadow registers written by software
  reg [15:0] dev_ctrl_ff; // device control, per function
  reg [15:0] dev_ctrl2_ff; // device control two
  reg [15:0] slot_ctrl_ff; // slot control, root port only
  reg [15:0] link_ctrl_ff; // primary link control
  reg [15:0] link_ctrl2_ff; // secondary link control
  reg [15:0] prm_cmd_ff; // primary command/status
  reg [7:0] root_ctrl_ff; // root control, root port only
  reg [15:0] sec_ctrl_ff; // secondary control
  reg [7:0] sec_bus_ff; // secondary bus number
  reg [7:0] sub_bus_ff; // subordinate bus number
  reg [31:0] msi_addr_lo_ff; // msi address low word
  reg [31:0] msi_addr_hi_ff; // msi address high word
  reg [19:0] io_base_ff; // i/o base upper bits
  reg [19:0] io_limit_ff; // i/o limit upper bits
  reg [11:0] nonprefetch_base_ff; // non-prefetchable base
  reg [11:0] nonprefetch_limit_ff; // non-prefetchable limit
  reg [31:0] prefetch_base_lo_ff; // prefetchable base low
  reg [31:0] prefetch_base_hi_ff; // prefetchable base upper
  reg [31:0] prefetch_limit_lo_ff; // prefetchable limit low
  reg [31:0] prefetch_limit_hi_ff; // prefetchable limit upper
  reg [31:0] pmcsr_ff; // power management control/status
  reg [15:0] msix_control_ff; // msi-x control
  reg [15:0] msi_control_ff; // msi control
  reg tx_ecrc_gen_ff; // transmit ecrc generation enable
  reg rx_ecrc_chk_ff; // receive ecrc check enable
  reg [23:0] traffic_class_channel_map_ff; // tc to vc map
  reg [15:0] msi_data_ff; // msi data
  reg [12:0] bus_dev_ff; // bus and device number
  reg [15:0] link_status_ff; // link status as written by software
  reg gen2_ff; // speed variant: 1 = second generation
  reg root_port_ff; // operating mode: 1 = root port
  // mirror state
  wire step; // one pulse per hold period
  reg [31:0] nxt_mirror; // bus contents for the next index
  reg [31:0] nxt_rdata; // read mux
  reg [15:0] link_status_rep; // link status with bandwidth bit forced
  wire [3:0] nxt_index = config_mirror_index_ff + 4'h1;
  wire sel = wr_en;

  // divider that sets the pace of the round robin
  csmm_hold_timer #(
    .HOLD(HOLD_CYCLES),
    .CW(3)
  ) u_timer (
    .clock(clock),
    .rst_n(rst_n),
    .step_ff(step)
  );

  // bandwidth notification bit follows the speed variant, never software
  always @* begin
    link_status_rep = link_status_ff;
    link_status_rep[`CSMM_LINK_BW_BIT] = gen2_ff;
  end

  // layout of the group that comes up next; fields sit at fixed bus lanes,
  // bit ranges in names refer to the source register, not the bus
  always @* begin
    case (nxt_index)
      4'h0: nxt_mirror = {dev_ctrl_ff, dev_ctrl2_ff};
      4'h1: nxt_mirror = {16'h0000, slot_ctrl_ff};
      4'h2: nxt_mirror = {link_ctrl_ff, link_ctrl2_ff};
      4'h3: nxt_mirror = {8'h00, prm_cmd_ff, root_ctrl_ff};
      4'h4: nxt_mirror = {sec_ctrl_ff, sec_bus_ff, sub_bus_ff};
      4'h5: nxt_mirror = {msi_addr_lo_ff[11:0], io_base_ff};
      4'h6: nxt_mirror = {msi_addr_hi_ff[11:0], io_limit_ff};
      4'h7: nxt_mirror = {8'h00, nonprefetch_base_ff, nonprefetch_limit_ff};
      4'h8: nxt_mirror = prefetch_base_lo_ff;
      4'h9: nxt_mirror = {prefetch_limit_hi_ff[11:0], prefetch_base_hi_ff[19:0]};
      4'ha: nxt_mirror = prefetch_limit_lo_ff;
      4'hb: nxt_mirror = {prefetch_limit_hi_ff[31:12], prefetch_base_hi_ff[31:20]};
      4'hc: nxt_mirror = pmcsr_ff;
      4'hd: nxt_mirror = {msix_control_ff, msi_control_ff};
      4'he: nxt_mirror = {6'h00, tx_ecrc_gen_ff, rx_ecrc_chk_ff,
                          traffic_class_channel_map_ff};
      4'hf: nxt_mirror = {msi_data_ff[15:0], 3'h0, bus_dev_ff};
      default: nxt_mirror = 32'h00000000;
    endcase
  end

  // index and bus change together so a latch by index never sees a mix
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      config_mirror_index_ff <= 4'hf;
      config_mirror_bus_ff <= `CSMM_RST_32;
      config_status_bus_ff <= 53'h0;
    end else begin
      if (step) begin
        config_mirror_index_ff <= nxt_index;
        config_mirror_bus_ff <= nxt_mirror;
      end
      // link status is kept on its lanes at all times, including index 2
      config_status_bus_ff <= 53'h0;
      config_status_bus_ff[`CSMM_STS_LINK_MSB:`CSMM_STS_LINK_LSB] <= link_status_rep;
    end
  end

  // software writes; stored as written, size codes are passed through
  // untouched so the application decodes them with the standard table
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dev_ctrl_ff <= `CSMM_RST_16;
      dev_ctrl2_ff <= `CSMM_RST_16;
      slot_ctrl_ff <= `CSMM_RST_16;
      link_ctrl_ff <= `CSMM_RST_16;
      link_ctrl2_ff <= `CSMM_RST_16;
      prm_cmd_ff <= `CSMM_RST_16;
      root_ctrl_ff <= 8'h00;
      sec_ctrl_ff <= `CSMM_RST_16;
      sec_bus_ff <= 8'h00;
      sub_bus_ff <= 8'h00;
      msi_addr_lo_ff <= `CSMM_RST_32;
      msi_addr_hi_ff <= `CSMM_RST_32;
      io_base_ff <= 20'h00000;
      io_limit_ff <= 20'h00000;
      nonprefetch_base_ff <= 12'h000;
      nonprefetch_limit_ff <= 12'h000;
      prefetch_base_lo_ff <= `CSMM_RST_32;
      prefetch_base_hi_ff <= `CSMM_RST_32;
      prefetch_limit_lo_ff <= `CSMM_RST_32;
      prefetch_limit_hi_ff <= `CSMM_RST_32;
      pmcsr_ff <= `CSMM_RST_32;
      msix_control_ff <= `CSMM_RST_16;
      msi_control_ff <= `CSMM_RST_16;
      tx_ecrc_gen_ff <= 1'b0;
      rx_ecrc_chk_ff <= 1'b0;
      traffic_class_channel_map_ff <= 24'h000000;
      msi_data_ff <= `CSMM_RST_16;
      bus_dev_ff <= 13'h0;
      link_status_ff <= `CSMM_RST_16;
      gen2_ff <= 1'b0;
      root_port_ff <= 1'b0;
    end else if (sel) begin
      case (addr)
        `CSMM_ADDR_DEV_CTRL: dev_ctrl_ff <= wdata[15:0];
        `CSMM_ADDR_DEV_CTRL2: dev_ctrl2_ff <= wdata[15:0];
        `CSMM_ADDR_SLOT_CTRL: slot_ctrl_ff <= wdata[15:0];
        `CSMM_ADDR_LINK_CTRL: link_ctrl_ff <= wdata[15:0];
        `CSMM_ADDR_LINK_CTRL2: link_ctrl2_ff <= wdata[15:0];
        `CSMM_ADDR_CMD_ROOT: begin
          prm_cmd_ff <= wdata[23:8];
          root_ctrl_ff <= wdata[7:0];
        end
        `CSMM_ADDR_SEC_BUS: begin
          sec_ctrl_ff <= wdata[31:16];
          sec_bus_ff <= wdata[15:8];
          sub_bus_ff <= wdata[7:0];
        end
        `CSMM_ADDR_MSI_ADDR_LO: msi_addr_lo_ff <= wdata;
        `CSMM_ADDR_MSI_ADDR_HI: msi_addr_hi_ff <= wdata;
        `CSMM_ADDR_IO_BASE: io_base_ff <= wdata[19:0];
        `CSMM_ADDR_IO_LIMIT: io_limit_ff <= wdata[19:0];
        `CSMM_ADDR_NP: begin
          nonprefetch_base_ff <= wdata[23:12];
          nonprefetch_limit_ff <= wdata[11:0];
        end
        `CSMM_ADDR_PF_BASE_LO: prefetch_base_lo_ff <= wdata;
        `CSMM_ADDR_PF_BASE_HI: prefetch_base_hi_ff <= wdata;
        `CSMM_ADDR_PF_LIM_LO: prefetch_limit_lo_ff <= wdata;
        `CSMM_ADDR_PF_LIM_HI: prefetch_limit_hi_ff <= wdata;
        `CSMM_ADDR_PMCSR: pmcsr_ff <= wdata;
        `CSMM_ADDR_MSI_CTRL: begin
          msix_control_ff <= wdata[31:16];
          msi_control_ff <= wdata[15:0];
        end
        `CSMM_ADDR_ECRC_TCVC: begin
          tx_ecrc_gen_ff <= wdata[`CSMM_TX_ECRC_BIT];
          rx_ecrc_chk_ff <= wdata[`CSMM_RX_ECRC_BIT];
          traffic_class_channel_map_ff <= wdata[23:0];
        end
        `CSMM_ADDR_MSI_DATA_BUSDEV: begin
          msi_data_ff <= wdata[31:16];
          bus_dev_ff <= wdata[12:0];
        end
        `CSMM_ADDR_LINK_STATUS: link_status_ff <= wdata[15:0];
        `CSMM_ADDR_MODE: begin
          gen2_ff <= wdata[`CSMM_MODE_GEN2_BIT];
          root_port_ff <= wdata[`CSMM_MODE_ROOT_BIT];
        end
        default: ; // unmapped or read-only: write ignored
      endcase
    end
  end

  // read mux; unmapped addresses answer zero
  always @* begin
    case (addr)
      `CSMM_ADDR_DEV_CTRL: nxt_rdata = {16'h0000, dev_ctrl_ff};
      `CSMM_ADDR_DEV_CTRL2: nxt_rdata = {16'h0000, dev_ctrl2_ff};
      `CSMM_ADDR_SLOT_CTRL: nxt_rdata = {16'h0000, slot_ctrl_ff};
      `CSMM_ADDR_LINK_CTRL: nxt_rdata = {16'h0000, link_ctrl_ff};
      `CSMM_ADDR_LINK_CTRL2: nxt_rdata = {16'h0000, link_ctrl2_ff};
      `CSMM_ADDR_CMD_ROOT: nxt_rdata = {8'h00, prm_cmd_ff, root_ctrl_ff};
      `CSMM_ADDR_SEC_BUS: nxt_rdata = {sec_ctrl_ff, sec_bus_ff, sub_bus_ff};
      `CSMM_ADDR_MSI_ADDR_LO: nxt_rdata = msi_addr_lo_ff;
      `CSMM_ADDR_MSI_ADDR_HI: nxt_rdata = msi_addr_hi_ff;
      `CSMM_ADDR_IO_BASE: nxt_rdata = {12'h000, io_base_ff};
      `CSMM_ADDR_IO_LIMIT: nxt_rdata = {12'h000, io_limit_ff};
      `CSMM_ADDR_NP: nxt_rdata = {8'h00, nonprefetch_base_ff, nonprefetch_limit_ff};
      `CSMM_ADDR_PF_BASE_LO: nxt_rdata = prefetch_base_lo_ff;
      `CSMM_ADDR_PF_BASE_HI: nxt_rdata = prefetch_base_hi_ff;
      `CSMM_ADDR_PF_LIM_LO: nxt_rdata = prefetch_limit_lo_ff;
      `CSMM_ADDR_PF_LIM_HI: nxt_rdata = prefetch_limit_hi_ff;
      `CSMM_ADDR_PMCSR: nxt_rdata = pmcsr_ff;
      `CSMM_ADDR_MSI_CTRL: nxt_rdata = {msix_control_ff, msi_control_ff};
      `CSMM_ADDR_ECRC_TCVC: nxt_rdata = {6'h00, tx_ecrc_gen_ff, rx_ecrc_chk_ff,
                                         traffic_class_channel_map_ff};
      `CSMM_ADDR_MSI_DATA_BUSDEV: nxt_rdata = {msi_data_ff, 3'h0, bus_dev_ff};
      `CSMM_ADDR_LINK_STATUS: nxt_rdata = {16'h0000, link_status_rep};
      `CSMM_ADDR_MODE: nxt_rdata = {30'h0, root_port_ff, gen2_ff};
      `CSMM_ADDR_INDEX: nxt_rdata = {28'h0000000, config_mirror_index_ff};
      default: nxt_rdata = 32'h00000000;
    endcase
  end

  // read data stands only in the cycle after the read strobe
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= `CSMM_RST_32;
    end else begin
      rdata_ff <= rd_en ? nxt_rdata : 32'h00000000;
    end
  end
endmodule
